// ---- logic/usart_core.sv ----
// Serial transceiver core: transmit buffer, receiver, receive FIFO, pins
`timescale 1ns/1ns
`default_nettype none
module usart_core
  import usart_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Configuration
  input  wire logic        tx_enable_in,
  input  wire logic        rx_enable_in,
  input  wire logic        one_wire_in,
  input  wire logic        spi_mode_in,
  input  wire logic        bit_order_select_in,
  input  wire logic [1:0]  parity_select_in,
  input  wire logic [3:0]  char_size_in,
  input  wire logic        two_stop_in,
  input  wire logic [1:0]  receive_mode_field_in,
  input  wire logic [15:0] baud_div_in,
  // Transmit side of the host
  input  wire logic        tx_write_in,
  input  wire logic [8:0]  tx_data_in,
  input  wire logic        tx_complete_clear_in,
  output logic             tx_buffer_empty_flag_out,
  output logic             tx_complete_flag_out,
  // Receive side of the host
  input  wire logic        rx_read_in,
  output logic [8:0]       rx_data_out,
  output logic             framing_fault_flag_out,
  output logic             rx_overrun_flag_out,
  output logic             parity_fault_flag_out,
  output logic             rx_complete_flag_out,
  // Serial pins
  input  wire logic        rx_line_in,
  output logic             txd_out,
  output logic             txd_oe_n_out,
  output logic             transfer_clock_pin_out,
  output logic             xck_oe_n_out
);
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_state_t;

  logic [15:0]        div_reg;
  logic               tick_reg;
  logic [4:0]         spb;
  logic [4:0]         vote_lo;
  logic [4:0]         vote_hi;
  logic [3:0]         nb;
  logic [8:0]         tx_buf_reg;
  logic               eng_busy;
  logic               eng_done;
  logic               eng_load;
  logic [7:0]         spi_rx;
  rx_state_t          r_state_reg;
  logic [4:0]         scnt_reg;
  logic [3:0]         rbit_reg;
  logic [1:0]         votes_reg;
  logic               prev_reg;
  logic [8:0]         rdat_reg;
  logic               rpar_reg;
  logic               lin_pid_reg;
  logic               voted;
  logic               decide;
  logic               bit_end;
  logic               rx_on;
  logic               push;
  logic [ENTRY_W-1:0] push_entry;
  logic [ENTRY_W-1:0] head;
  logic               parity_fault_flag;
  logic               pid_ok;

  // Sample tick divider; one tick per oversample
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg >= baud_div_in) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= 16'(div_reg + 16'h1);
      tick_reg <= 1'b0;
    end
  end

  assign spb     = (receive_mode_field_in == RXM_DOUBLE) ? SPB_DOUBLE : SPB_NORMAL;
  assign vote_lo = spb >> 1;
  assign vote_hi = 5'(vote_lo + VOTE_SPAN);
  assign nb      = spi_mode_in ? SPI_BITS : char_size_in;

  // Transmit buffer: accepted only while empty, then handed to the engine
  assign eng_load = !tx_buffer_empty_flag_out && !eng_busy;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_buf_reg               <= '0;
      tx_buffer_empty_flag_out <= 1'b1;
    end else if (tx_write_in && tx_buffer_empty_flag_out && tx_enable_in) begin
      tx_buf_reg               <= tx_data_in;
      tx_buffer_empty_flag_out <= 1'b0;
    end else if (eng_load) begin
      tx_buffer_empty_flag_out <= 1'b1;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_complete_flag_out <= 1'b0;
    end else if (eng_done && tx_buffer_empty_flag_out) begin
      tx_complete_flag_out <= 1'b1;
    end else if (tx_complete_clear_in || tx_write_in) begin
      tx_complete_flag_out <= 1'b0;
    end
  end

  // Pin override drops only once nothing is left to send
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      txd_oe_n_out <= 1'b1;
      xck_oe_n_out <= 1'b1;
    end else if (tx_enable_in) begin
      txd_oe_n_out <= 1'b0;
      xck_oe_n_out <= !spi_mode_in;
    end else if (tx_buffer_empty_flag_out && !eng_busy) begin
      txd_oe_n_out <= 1'b1;
      xck_oe_n_out <= 1'b1;
    end
  end

  tx_engine u_tx (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .tick_in      (tick_reg),
    .spb_in       (spb),
    .spi_mode_in  (spi_mode_in),
    .msb_first_in (bit_order_select_in),
    .parity_in    (parity_select_in),
    .nbits_in     (char_size_in),
    .two_stop_in  (two_stop_in),
    .load_in      (eng_load),
    .data_in      (tx_buf_reg),
    .miso_in      (rx_line_in),
    .busy_out     (eng_busy),
    .done_out     (eng_done),
    .line_out     (txd_out),
    .xck_out      (transfer_clock_pin_out),
    .spi_rx_out   (spi_rx)
  );

  // Asynchronous receiver
  assign rx_on   = rx_enable_in && !spi_mode_in;
  assign voted   = majority3({votes_reg, rx_line_in});
  assign decide  = tick_reg && scnt_reg == vote_hi;
  assign bit_end = tick_reg && scnt_reg == spb;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_reg  <= 1'b1;
      votes_reg <= '0;
    end else if (tick_reg) begin
      prev_reg <= rx_line_in;
      if (scnt_reg >= vote_lo && scnt_reg < vote_hi) begin
        votes_reg <= {votes_reg[0], rx_line_in};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_state_reg <= R_IDLE;
      scnt_reg    <= '0;
      rbit_reg    <= '0;
      rdat_reg    <= '0;
      rpar_reg    <= 1'b0;
    end else if (!rx_on) begin
      r_state_reg <= R_IDLE;
      scnt_reg    <= '0;
    end else if (r_state_reg == R_IDLE) begin
      if (tick_reg && prev_reg && !rx_line_in) begin
        r_state_reg <= R_START;
        // This tick is sample one, so the next tick must read as sample two
        scnt_reg    <= 5'h02;
        rbit_reg    <= '0;
        rdat_reg    <= '0;
      end
    end else if (tick_reg) begin
      scnt_reg <= bit_end ? 5'h01 : 5'(scnt_reg + 5'h01);
      if (decide) begin
        unique case (r_state_reg)
          R_START: if (voted) r_state_reg <= R_IDLE;
          R_DATA:  rdat_reg[rbit_reg] <= voted;
          R_PAR:   rpar_reg <= voted;
          R_STOP:  r_state_reg <= R_IDLE;
          default: r_state_reg <= R_IDLE;
        endcase
      end else if (bit_end) begin
        unique case (r_state_reg)
          R_START: r_state_reg <= R_DATA;
          R_DATA: begin
            if (rbit_reg != 4'(nb - 4'h1)) begin
              rbit_reg <= 4'(rbit_reg + 4'h1);
            end else begin
              r_state_reg <= parity_select_in[1] ? R_PAR : R_STOP;
            end
          end
          R_PAR:   r_state_reg <= R_STOP;
          default: r_state_reg <= R_IDLE;
        endcase
      end
    end
  end

  // Protected identifier: P0 is bit 6, P1 is bit 7
  assign pid_ok = (rdat_reg[6] == (rdat_reg[0] ^ rdat_reg[1] ^ rdat_reg[2] ^ rdat_reg[4]))
               && (rdat_reg[7] == !(rdat_reg[1] ^ rdat_reg[3] ^ rdat_reg[4] ^ rdat_reg[5]));

  always_comb begin
    if (receive_mode_field_in == RXM_LIN) begin
      parity_fault_flag = lin_pid_reg && !pid_ok;
    end else begin
      parity_fault_flag = parity_select_in[1]
          && rpar_reg != data_parity(rdat_reg, nb, parity_select_in == PAR_ODD);
    end
  end

  always_comb begin
    push       = 1'b0;
    push_entry = '0;
    if (spi_mode_in) begin
      push                      = eng_done && rx_enable_in;
      push_entry[DATA_W-1:0]    = {1'b0, spi_rx};
    end else if (rx_on && decide && r_state_reg == R_STOP) begin
      push                      = 1'b1;
      push_entry[DATA_W-1:0]    = rdat_reg;
      push_entry[E_FRAMING_FAULT_FLAG]        = !voted;
      push_entry[E_PARITY_FAULT_FLAG]        = parity_fault_flag;
    end
  end

  // The frame after a sync byte is taken as the protected identifier
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lin_pid_reg <= 1'b0;
    end else if (!rx_on) begin
      lin_pid_reg <= 1'b0;
    end else if (push) begin
      lin_pid_reg <= (push_entry[7:0] == LIN_SYNC);
    end
  end

  rx_fifo #(
    .W     (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .flush_in  (!rx_enable_in),
    .push_in   (push),
    .data_in   (push_entry),
    .pop_in    (rx_read_in),
    .head_out  (head),
    .valid_out (rx_complete_flag_out),
    .full_out  ()
  );

  assign rx_data_out            = head[DATA_W-1:0];
  assign framing_fault_flag_out = head[E_FRAMING_FAULT_FLAG];
  assign rx_overrun_flag_out    = head[E_OVF];
  assign parity_fault_flag_out  = head[E_PARITY_FAULT_FLAG];

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence start_vote_high;
    r_state_reg == R_START && decide && voted;
  endsequence

  sequence start_vote_low;
    rx_on && r_state_reg == R_START && decide && !voted;
  endsequence

  sequence stop_sampled;
    rx_on && r_state_reg == R_STOP && decide;
  endsequence

  chk_start_reject: assert property (start_vote_high |=> r_state_reg == R_IDLE)
    else $error("noisy start bit not rejected");
  chk_start_accept: assert property (start_vote_low |=> r_state_reg == R_START)
    else $error("valid start bit lost");
  chk_stop_framing_fault_flag: assert property (stop_sampled ##0 !voted ##0 !rx_complete_flag_out
      |=> framing_fault_flag_out)
    else $error("low stop bit without frame fault");
  chk_rx_flush: assert property (!rx_enable_in |=> !rx_complete_flag_out)
    else $error("receive buffer kept data after disable");
  chk_rx_store: assert property (push |=> rx_complete_flag_out)
    else $error("completed frame not visible");
  chk_rx_upper_zero: assert property (rx_complete_flag_out && !spi_mode_in
      && char_size_in == 4'h5 && $stable(char_size_in) |-> rx_data_out[8:5] == 4'h0)
    else $error("unused receive bits not zero");
  chk_tx_release: assert property ($rose(txd_oe_n_out) |->
      $past(tx_buffer_empty_flag_out) && !$past(eng_busy))
    else $error("transmit pin released with data pending");
  chk_tx_drive: assert property (tx_enable_in |=> !txd_oe_n_out)
    else $error("enabled transmitter not driving pin");
  chk_tx_idle_high: assert property (!eng_busy && !$past(eng_busy) |-> txd_out)
    else $error("idle line not high");
  chk_tx_load: assert property (eng_load |=> eng_busy ##0 tx_buffer_empty_flag_out)
    else $error("buffered data not loaded");
  chk_txc_set: assert property (eng_done && tx_buffer_empty_flag_out
      |=> tx_complete_flag_out)
    else $error("transmit complete not set");
endmodule
`default_nettype wire

// ---- logic/usart_pkg.sv ----
// Shared constants and helpers for the serial transceiver core
`default_nettype none
package usart_pkg;
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam logic [4:0]  SPB_NORMAL = 5'h10;
  localparam logic [4:0]  SPB_DOUBLE = 5'h08;
  localparam logic [4:0]  VOTE_SPAN  = 5'h02;
  localparam logic [3:0]  SPI_BITS   = 4'h8;
  localparam logic [7:0]  LIN_SYNC   = 8'h55;
  localparam logic [1:0]  PAR_EVEN   = 2'h2;
  localparam logic [1:0]  PAR_ODD    = 2'h3;
  localparam logic [1:0]  RXM_NORMAL = 2'h0;
  localparam logic [1:0]  RXM_DOUBLE = 2'h1;
  localparam logic [1:0]  RXM_LIN    = 2'h2;
  localparam int          DATA_W     = 9;
  localparam int          ENTRY_W    = 12;
  localparam int          E_OVF      = 11;
  localparam int          E_FRAMING_FAULT_FLAG     = 10;
  localparam int          E_PARITY_FAULT_FLAG     = 9;
  localparam int          FIFO_DEPTH = 2;

  // Parity bit over the low n data bits; odd seeds the sum with one
  function automatic logic data_parity(input logic [8:0] d, input logic [3:0] n,
                                       input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < int'(n)) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction

  function automatic logic majority3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
endpackage
`default_nettype wire

// ---- logic/rx_fifo.sv ----
// Receive FIFO holding each frame with its error flags, head at entry zero
`timescale 1ns/1ns
`default_nettype none
module rx_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Control
  input  wire logic         flush_in,
  input  wire logic         push_in,
  input  wire logic [W-1:0] data_in,
  input  wire logic         pop_in,
  // Head and state
  output logic      [W-1:0] head_out,
  output logic              valid_out,
  output logic              full_out
);
  logic [W-1:0]     mem_reg [DEPTH];
  logic [W-1:0]     mem_next [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH-1:0] vld_next;

  always_comb begin
    int slot;
    slot = 0;
    mem_next = mem_reg;
    vld_next = vld_reg;
    if (pop_in && vld_reg[0]) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_next[i] = mem_reg[i+1];
      end
      vld_next = vld_reg >> 1;
    end
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!vld_next[i]) begin
        slot = i;
      end
    end
    if (push_in) begin
      if (!vld_next[DEPTH-1]) begin
        mem_next[slot] = data_in;
        vld_next[slot] = 1'b1;
      end else begin
        // Frame dropped: the newest stored frame carries the overflow mark
        mem_next[DEPTH-1][W-1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vld_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (flush_in) begin
      vld_reg <= '0;
    end else begin
      vld_reg <= vld_next;
      mem_reg <= mem_next;
    end
  end

  assign head_out  = mem_reg[0];
  assign valid_out = vld_reg[0];
  assign full_out  = vld_reg[DEPTH-1];
endmodule
`default_nettype wire

// ---- logic/tx_engine.sv ----
// Transmit shift engine for asynchronous frames and master SPI bytes
`timescale 1ns/1ns
`default_nettype none
module tx_engine
  import usart_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Timing and format
  input  wire logic       tick_in,
  input  wire logic [4:0] spb_in,
  input  wire logic       spi_mode_in,
  input  wire logic       msb_first_in,
  input  wire logic [1:0] parity_in,
  input  wire logic [3:0] nbits_in,
  input  wire logic       two_stop_in,
  // Frame load
  input  wire logic       load_in,
  input  wire logic [8:0] data_in,
  input  wire logic       miso_in,
  // Status and pins
  output logic            busy_out,
  output logic            done_out,
  output logic            line_out,
  output logic            xck_out,
  output logic [7:0]      spi_rx_out
);
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_state_t;
  tx_state_t  state_reg;
  logic [8:0] sh_reg;
  logic [4:0] cnt_reg;
  logic [3:0] bit_reg;
  logic       stop2_reg;
  logic [3:0] nb;
  logic [3:0] idx;
  logic       line_next;

  assign nb       = spi_mode_in ? SPI_BITS : nbits_in;
  // Bit order applies to SPI bytes only; asynchronous frames always go lsb first
  assign idx      = (spi_mode_in && msb_first_in) ? 4'(nb - 4'h1 - bit_reg) : bit_reg;
  assign busy_out = (state_reg != T_IDLE);

  always_comb begin
    line_next = 1'b1;
    unique case (state_reg)
      T_IDLE:  line_next = 1'b1;
      T_START: line_next = 1'b0;
      T_DATA:  line_next = sh_reg[idx];
      T_PAR:   line_next = data_parity(sh_reg, nb, parity_in == PAR_ODD);
      T_STOP:  line_next = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= T_IDLE;
      sh_reg    <= '0;
      cnt_reg   <= '0;
      bit_reg   <= '0;
      stop2_reg <= 1'b0;
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (state_reg == T_IDLE) begin
        if (load_in) begin
          sh_reg    <= data_in;
          cnt_reg   <= '0;
          bit_reg   <= '0;
          stop2_reg <= 1'b0;
          state_reg <= spi_mode_in ? T_DATA : T_START;
        end
      end else if (tick_in) begin
        if (cnt_reg != 5'(spb_in - 5'h1)) begin
          cnt_reg <= 5'(cnt_reg + 5'h1);
        end else begin
          cnt_reg <= '0;
          unique case (state_reg)
            T_START: state_reg <= T_DATA;
            T_DATA: begin
              if (bit_reg != 4'(nb - 4'h1)) begin
                bit_reg <= 4'(bit_reg + 4'h1);
              end else if (spi_mode_in) begin
                state_reg <= T_IDLE;
                done_out  <= 1'b1;
              end else begin
                state_reg <= parity_in[1] ? T_PAR : T_STOP;
              end
            end
            T_PAR:   state_reg <= T_STOP;
            default: begin
              if (two_stop_in && !stop2_reg) begin
                stop2_reg <= 1'b1;
              end else begin
                state_reg <= T_IDLE;
                done_out  <= 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // Line and clock pins are registered one cycle after the state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_out <= 1'b1;
      xck_out  <= 1'b0;
    end else begin
      line_out <= line_next;
      xck_out  <= spi_mode_in && state_reg == T_DATA && cnt_reg >= (spb_in >> 1);
    end
  end

  // SPI input is taken where the clock rises, mid bit
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      spi_rx_out <= '0;
    end else if (spi_mode_in && state_reg == T_DATA && tick_in
                 && cnt_reg == (spb_in >> 1)) begin
      spi_rx_out[idx[2:0]] <= miso_in;
    end
  end
endmodule
`default_nettype wire

// ---- dv/far_uart.sv ----
// Far-end serial transceiver model: drives the receive line, samples the transmit line
`timescale 1ns/1ns
`default_nettype none
module far_uart (
  // Clock and pins
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      line_out
);
  int spb = 16;

  // Idle line is high between frames
  initial line_out = 1'b1;

  task automatic put(input logic b);
    @(negedge clk_in);
    line_out = b;
    repeat (spb - 1) @(negedge clk_in);
  endtask

  // Start, n data bits lsb first, optional parity, one stop of chosen level
  task automatic send(input logic [8:0] dat, input int n, input int par, input logic stop);
    logic p;
    p = par[0];
    put(1'b0);
    for (int i = 0; i < n; i++) begin
      put(dat[i]);
      p = p ^ dat[i];
    end
    if (par > 1) put(p);
    put(stop);
    line_out = 1'b1;
  endtask

  // Low pulse far shorter than the vote point, then a long quiet gap
  task automatic glitch();
    @(negedge clk_in);
    line_out = 1'b0;
    repeat (3) @(negedge clk_in);
    line_out = 1'b1;
    repeat (2 * spb) @(negedge clk_in);
  endtask

  // Sampled at bit centres on the falling clock edge, clear of output updates
  task automatic recv(input int n, input int par, output logic [8:0] dat, output logic pb,
                      output logic st);
    int k;
    dat = '0;
    pb = 1'b0;
    k = 0;
    while (txd_in !== 1'b0 && k < 4000) begin
      @(negedge clk_in);
      k++;
    end
    repeat (spb / 2) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      repeat (spb) @(negedge clk_in);
      dat[i] = txd_in;
    end
    if (par > 1) begin
      repeat (spb) @(negedge clk_in);
      pb = txd_in;
    end
    repeat (spb) @(negedge clk_in);
    st = txd_in;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the serial transceiver core
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import usart_pkg::*;
  logic        clk_in = 1'b0;
  logic        rstn_in, tx_enable_in, rx_enable_in, one_wire_in, spi_mode_in;
  logic        bit_order_select_in, two_stop_in, tx_write_in, tx_complete_clear_in;
  logic        rx_read_in, tx_buffer_empty_flag_out, tx_complete_flag_out, txd_out;
  logic        framing_fault_flag_out, rx_overrun_flag_out, parity_fault_flag_out;
  logic        rx_complete_flag_out, txd_oe_n_out, transfer_clock_pin_out, xck_oe_n_out;
  logic        pb, st;
  logic [1:0]  parity_select_in, receive_mode_field_in;
  logic [3:0]  char_size_in;
  logic [15:0] baud_div_in;
  logic [8:0]  tx_data_in, rx_data_out, d, got;
  wire         rx_line_in;
  int          num_errors = 0;
  int          checks_done = 0;

  usart_core i_dut (.clk_in, .rstn_in, .tx_enable_in, .rx_enable_in, .one_wire_in,
    .spi_mode_in, .bit_order_select_in, .parity_select_in, .char_size_in, .two_stop_in,
    .receive_mode_field_in, .baud_div_in, .tx_write_in, .tx_data_in, .tx_complete_clear_in,
    .tx_buffer_empty_flag_out, .tx_complete_flag_out, .rx_read_in, .rx_data_out,
    .framing_fault_flag_out, .rx_overrun_flag_out, .parity_fault_flag_out,
    .rx_complete_flag_out, .rx_line_in, .txd_out, .txd_oe_n_out, .transfer_clock_pin_out,
    .xck_oe_n_out);
  far_uart i_far (.clk_in(clk_in), .txd_in(txd_out), .line_out(rx_line_in));

  always #10 clk_in = ~clk_in;

  task automatic close_out();
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [8:0] g, input logic [8:0] e);
    checks_done++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask

  // Write only once the buffer reports empty
  task automatic wr(input logic [8:0] v);
    int k;
    k = 0;
    while (tx_buffer_empty_flag_out !== 1'b1 && k < 1000) begin
      @(negedge clk_in);
      k++;
    end
    tx_data_in = v;
    tx_write_in = 1'b1;
    @(negedge clk_in);
    tx_write_in = 1'b0;
  endtask

  // Flags are taken before the pop that advances the FIFO
  task automatic rd(input logic [8:0] ed, input logic [2:0] ef);
    int k;
    k = 0;
    while (rx_complete_flag_out !== 1'b1 && k < 400) begin
      @(negedge clk_in);
      k++;
    end
    check(rx_data_out, ed);
    check({6'h0, rx_overrun_flag_out, framing_fault_flag_out, parity_fault_flag_out}, {6'h0, ef});
    rx_read_in = 1'b1;
    @(negedge clk_in);
    rx_read_in = 1'b0;
    @(negedge clk_in);
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    close_out();
  end

  initial begin
    {rstn_in, tx_enable_in, one_wire_in, spi_mode_in, bit_order_select_in} = '0;
    {two_stop_in, tx_write_in, tx_complete_clear_in, rx_read_in} = '0;
    rx_enable_in = 1'b1;
    parity_select_in = PAR_EVEN;
    char_size_in = 4'h8;
    receive_mode_field_in = RXM_NORMAL;
    baud_div_in = 16'h0000;
    tx_data_in = 9'h000;
    repeat (16) @(negedge clk_in);
    rstn_in = 1'b1;
    check({5'h0, txd_out, txd_oe_n_out, tx_buffer_empty_flag_out, tx_complete_flag_out}, 9'h00e);
    tx_enable_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check({7'h0, txd_oe_n_out, xck_oe_n_out}, 9'h001);
    fork
      i_far.recv(8, 2, d, pb, st);
      wr(9'h0a5);
    join
    check(d, 9'h0a5);
    check({7'h0, pb, st}, 9'h001);
    repeat (40) @(negedge clk_in);
    check({7'h0, tx_complete_flag_out, txd_out}, 9'h003);
    tx_complete_clear_in = 1'b1;
    @(negedge clk_in);
    tx_complete_clear_in = 1'b0;
    @(negedge clk_in);
    check({8'h0, tx_complete_flag_out}, 9'h000);
    // Bit 5 clear: a sixth data bit would land where the stop should be high
    char_size_in = 4'h5;
    parity_select_in = 2'h0;
    fork
      i_far.recv(5, 0, d, pb, st);
      wr(9'h1df);
    join
    check({st, d[7:0]}, 9'h11f);
    char_size_in = 4'h8;
    parity_select_in = PAR_EVEN;
    one_wire_in = 1'b1;
    two_stop_in = 1'b1;
    fork
      begin
        i_far.recv(8, 2, d, pb, st);
        check(d, 9'h03c);
        check({8'h0, txd_oe_n_out}, 9'h000);
        i_far.recv(8, 2, d, pb, st);
        check(d, 9'h0c3);
      end
      begin
        wr(9'h03c);
        wr(9'h0c3);
        tx_enable_in = 1'b0;
      end
    join
    repeat (60) @(negedge clk_in);
    check({7'h0, txd_oe_n_out, txd_out}, 9'h003);
    one_wire_in = 1'b0;
    two_stop_in = 1'b0;
    // Two frames fill the FIFO, the third is dropped and marks the newest entry
    i_far.send(9'h03c, 8, 2, 1'b1);
    i_far.send(9'h03c, 8, 3, 1'b1);
    i_far.send(9'h011, 8, 2, 1'b1);
    rd(9'h03c, 3'b000);
    rd(9'h03c, 3'b101);
    check({8'h0, rx_complete_flag_out}, 9'h000);
    i_far.send(9'h05a, 8, 2, 1'b0);
    rd(9'h05a, 3'b010);
    char_size_in = 4'h5;
    i_far.glitch();
    i_far.send(9'h015, 5, 2, 1'b1);
    rd(9'h015, 3'b000);
    check({8'h0, rx_complete_flag_out}, 9'h000);
    char_size_in = 4'h8;
    receive_mode_field_in = RXM_DOUBLE;
    i_far.spb = 8;
    i_far.send(9'h081, 8, 2, 1'b1);
    rd(9'h081, 3'b000);
    i_far.spb = 16;
    // Identifier zero: P0 = 0, P1 = 1 gives 0x80; 0x00 breaks P1
    receive_mode_field_in = RXM_LIN;
    parity_select_in = 2'h0;
    for (int i = 0; i < 2; i++) begin
      i_far.send({1'b0, LIN_SYNC}, 8, 0, 1'b1);
      rd({1'b0, LIN_SYNC}, 3'b000);
      i_far.send(i ? 9'h000 : 9'h080, 8, 0, 1'b1);
      rd(i ? 9'h000 : 9'h080, i ? 3'b001 : 3'b000);
    end
    receive_mode_field_in = RXM_NORMAL;
    i_far.send(9'h077, 8, 0, 1'b1);
    rx_enable_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rx_enable_in = 1'b1;
    check({8'h0, rx_complete_flag_out}, 9'h000);
    spi_mode_in = 1'b1;
    tx_enable_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check({7'h0, txd_oe_n_out, xck_oe_n_out}, 9'h000);
    for (int o = 0; o < 2; o++) begin
      bit_order_select_in = o[0];
      fork
        wr(9'h0a6);
        for (int b = 0; b < 8; b++) begin
          @(posedge transfer_clock_pin_out);
          got = {got[7:0], txd_out};
        end
      join
      check({1'b0, got[7:0]}, o ? 9'h0a6 : 9'h065);
      rd(9'h0ff, 3'b000);
    end
    close_out();
  end
endmodule
`default_nettype wire
